// file: rtl/twrs_pkg.sv
// Constants and register map of the two-wire register slave
// What this block does
// - Clock line input only; data line bidirectional
// - Slave address is 0111 plus strap pins
// - Strap pins latched at first bus access
// - Plain read returns byte at held address
// - Final address bit selects write or read
// - Bytes travel most significant bit first
// - Accept ack or not-ack after read byte
// - Ack address bytes; each read byte, acked or not, auto-increments
// - Not-ack on read ends transfer, releases line
// - Further written bytes go to next address
// - Writes to read-only registers get no ack
// - Timing derived only from the bus lines
// - No page buffer, byte-by-byte increment only
// - Only the low register set reachable; other offsets read 00h
// - Minimum frequency register reads 19h, ignores writes
// - Keep attempting panel presence detection
package twrs_pkg;
  localparam logic [3:0] ADDR_UPPER      = 4'h7;
  localparam logic [7:0] OFS_VENDOR_LO   = 8'h00;
  localparam logic [7:0] OFS_VENDOR_HI   = 8'h01;
  localparam logic [7:0] OFS_DEVICE_LO   = 8'h02;
  localparam logic [7:0] OFS_DEVICE_HI   = 8'h03;
  localparam logic [7:0] OFS_REVISION    = 8'h04;
  localparam logic [7:0] OFS_RESERVED    = 8'h05;
  localparam logic [7:0] OFS_MIN_FREQ    = 8'h06;
  localparam logic [7:0] OFS_MAX_FREQ    = 8'h07;
  localparam logic [7:0] OFS_CONFIG_ONE  = 8'h08;
  localparam logic [7:0] OFS_LOW_LAST    = 8'h0F;
  localparam logic [7:0] RST_RESERVED    = 8'hA5;
  localparam logic [7:0] RST_MIN_FREQ    = 8'h19;
  localparam logic [7:0] RST_CONFIG_ONE  = 8'h39;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam int         PRESENCE_BIT    = 2;
  localparam int         SYNC_STAGES     = 2;
endpackage

// file: rtl/twrs_reg_if.sv
// Register access carrier between the serial engine and the register file
`timescale 1ns/1ps
`default_nettype none
interface twrs_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic [7:0] rdata;
  logic       writable;
  modport master (output addr, output wdata, output wr, input rdata, input writable);
  modport slave  (input addr, input wdata, input wr, output rdata, output writable);
endinterface
`default_nettype wire

// file: rtl/twrs_regs.sv
// Register file of the low control set
`timescale 1ns/1ps
`default_nettype none
module twrs_regs #(
  parameter logic [7:0] VENDOR_LO = 8'h5A, // Arbitrary value
  parameter logic [7:0] VENDOR_HI = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEVICE_LO = 8'h6B, // Arbitrary value
  parameter logic [7:0] DEVICE_HI = 8'h2D, // Arbitrary value
  parameter logic [7:0] REVISION  = 8'h0E, // Arbitrary value
  parameter logic [7:0] MAX_FREQ  = 8'h41
) (
  input  wire logic   clock_in,
  input  wire logic   reset_n_in,
  input  wire logic   presence_in,
  twrs_reg_if.slave   bus,
  output logic [7:0]  config_one_out
);
  logic [7:0] dev_hi_r;
  logic [7:0] rev_r;
  logic [7:0] cfg_r;
  logic [7:0] spare0_r;
  logic [7:0] spare1_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Fixed registers are never writable
  assign bus.writable = (bus.addr == twrs_pkg::OFS_DEVICE_HI)  ||
                        (bus.addr == twrs_pkg::OFS_REVISION)   ||
                        (bus.addr == twrs_pkg::OFS_CONFIG_ONE) ||
                        (bus.addr == 8'h0E) || (bus.addr == 8'h0F);
  assign bus.rdata = rdata_r; // Serial port reaches only the low register set; other offsets read zero
  assign config_one_out = cfg_r;

  always_comb begin
    unique case (bus.addr)
      twrs_pkg::OFS_VENDOR_LO:  rdata_nxt = VENDOR_LO;
      twrs_pkg::OFS_VENDOR_HI:  rdata_nxt = VENDOR_HI;
      twrs_pkg::OFS_DEVICE_LO:  rdata_nxt = DEVICE_LO;
      twrs_pkg::OFS_DEVICE_HI:  rdata_nxt = dev_hi_r;
      twrs_pkg::OFS_REVISION:   rdata_nxt = rev_r;
      twrs_pkg::OFS_RESERVED:   rdata_nxt = twrs_pkg::RST_RESERVED;
      twrs_pkg::OFS_MIN_FREQ:   rdata_nxt = twrs_pkg::RST_MIN_FREQ;
      twrs_pkg::OFS_MAX_FREQ:   rdata_nxt = MAX_FREQ;
      twrs_pkg::OFS_CONFIG_ONE: rdata_nxt = cfg_r;
      8'h09:                    rdata_nxt = {5'h00, presence_in, 2'h0};
      8'h0E:                    rdata_nxt = spare0_r;
      8'h0F:                    rdata_nxt = spare1_r;
      default:                  rdata_nxt = twrs_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dev_hi_r <= DEVICE_HI;
      rev_r    <= REVISION;
      cfg_r    <= twrs_pkg::RST_CONFIG_ONE;
      spare0_r <= twrs_pkg::RST_ZERO;
      spare1_r <= twrs_pkg::RST_ZERO;
      rdata_r  <= twrs_pkg::RST_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
      if (bus.wr && bus.writable) begin
        unique case (bus.addr)
          twrs_pkg::OFS_DEVICE_HI:  dev_hi_r <= bus.wdata;
          twrs_pkg::OFS_REVISION:   rev_r    <= bus.wdata;
          twrs_pkg::OFS_CONFIG_ONE: cfg_r    <= bus.wdata;
          8'h0E:                    spare0_r <= bus.wdata;
          default:                  spare1_r <= bus.wdata;
        endcase
      end
    end
  end

  a_min_freq_fixed: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (bus.addr == twrs_pkg::OFS_MIN_FREQ) |=> (rdata_r == 8'h19))
    else $error("minimum frequency register not fixed");
endmodule
`default_nettype wire

// file: rtl/twrs_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module twrs_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r   <= '1;
      sync_out <= '1;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: rtl/twrs_top.sv
// Two-wire serial slave engine for the control registers
`timescale 1ns/1ps
`default_nettype none
module twrs_top (
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       addr_select_bit0_in,
  input  wire logic       addr_select_bit1_in,
  input  wire logic       addr_select_bit2_in,
  input  wire logic       panel_sense_in,
  output logic [7:0]      config_one_out,
  output logic            busy_out
);
  typedef enum logic [2:0] {
    TWRS_IDLE, TWRS_ADDR, TWRS_REG, TWRS_WDATA, TWRS_RDATA, TWRS_RACK, TWRS_ACK
  } twrs_state_t;

  twrs_reg_if rif ();

  // Bus pins are sampled by the system clock; 400 kHz still leaves about 60 clocks a bit
  logic [4:0] pins_s;
  twrs_sync #(.WIDTH(5)) u_sync (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   ({panel_sense_in, addr_select_bit2_in, addr_select_bit1_in,
                  addr_select_bit0_in, scl_in}),
    .sync_out   (pins_s)
  );
  logic sda_s;
  twrs_sync #(.WIDTH(1)) u_sync_sda (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .async_in   (sda_in),
    .sync_out   (sda_s)
  );

  twrs_regs u_regs (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    .presence_in    (pins_s[4]),
    .bus            (rif.slave),
    .config_one_out (config_one_out)
  );

  twrs_state_t state_r;
  twrs_state_t after_ack_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [2:0] bitcnt_r;
  logic [7:0] shift_r;
  logic [7:0] regaddr_r;
  logic [2:0] strap_r;
  logic       strap_done_r;
  logic       ack_drive_r;
  logic       ack_pend_r;
  logic       wr_r;
  logic [7:0] tx_r;

  // Edges seen only on synchronised copies; no internal clock meaning
  wire scl_rise  = pins_s[0] && !scl_d_r;
  wire scl_fall  = !pins_s[0] && scl_d_r;
  wire start_det = pins_s[0] && scl_d_r && !sda_s && sda_d_r;
  wire stop_det  = pins_s[0] && scl_d_r && sda_s && !sda_d_r;
  wire [7:0] rx_byte = {shift_r[6:0], sda_s};
  wire [2:0] strap_now = strap_done_r ? strap_r : pins_s[3:1];
  wire addr_hit = (rx_byte[7:1] == {twrs_pkg::ADDR_UPPER, strap_now});
  wire byte_end = scl_rise && (bitcnt_r == 3'd7);
  wire write_ok = rif.writable;

  assign rif.addr  = regaddr_r;
  assign rif.wdata = shift_r;
  assign rif.wr    = wr_r;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= pins_s[0];
      sda_d_r <= sda_s;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_r      <= 3'h0;
      strap_done_r <= 1'b0;
    end else if (start_det && !strap_done_r) begin
      strap_r      <= pins_s[3:1];
      strap_done_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r     <= TWRS_IDLE;
      after_ack_r <= TWRS_IDLE;
      bitcnt_r    <= 3'd0;
      shift_r     <= 8'h00;
      regaddr_r   <= 8'h00;
      ack_drive_r <= 1'b0;
      ack_pend_r  <= 1'b0;
      wr_r        <= 1'b0;
      tx_r        <= 8'hFF;
    end else begin
      wr_r <= 1'b0;
      if (start_det) begin
        state_r  <= TWRS_ADDR;
        bitcnt_r <= 3'd0;
        ack_drive_r <= 1'b0;
        ack_pend_r  <= 1'b0;
      end else if (stop_det) begin
        state_r  <= TWRS_IDLE;
        ack_drive_r <= 1'b0;
        ack_pend_r  <= 1'b0;
      end else begin
        unique case (state_r)
          TWRS_IDLE: ;
          TWRS_ADDR, TWRS_REG, TWRS_WDATA: begin
            if (scl_rise) begin
              shift_r  <= rx_byte;
              bitcnt_r <= bitcnt_r + 3'd1;
            end
            if (byte_end) begin
              if (state_r == TWRS_ADDR) begin
                if (addr_hit) begin
                  ack_pend_r  <= 1'b1;
                  after_ack_r <= rx_byte[0] ? TWRS_RDATA : TWRS_REG;
                  state_r     <= TWRS_ACK;
                end else begin
                  state_r <= TWRS_IDLE;
                end
              end else if (state_r == TWRS_REG) begin
                regaddr_r   <= rx_byte;
                ack_pend_r  <= 1'b1;
                after_ack_r <= TWRS_WDATA;
                state_r     <= TWRS_ACK;
              end else if (write_ok) begin
                wr_r        <= 1'b1;
                ack_pend_r  <= 1'b1;
                after_ack_r <= TWRS_WDATA;
                state_r     <= TWRS_ACK;
              end else begin
                state_r <= TWRS_IDLE;
              end
            end
          end
          TWRS_ACK: begin
            if (wr_r) begin
              regaddr_r <= regaddr_r + 8'h01;
            end
            // Ack goes out only once the clock is low again: pulling data low
            // while the clock is high would look like a start condition
            if (scl_fall && ack_pend_r) begin
              ack_pend_r  <= 1'b0;
              ack_drive_r <= 1'b1;
            end else if (scl_fall) begin
              ack_drive_r <= 1'b0;
              bitcnt_r    <= 3'd0;
              state_r     <= after_ack_r;
              tx_r        <= rif.rdata;
              if (after_ack_r == TWRS_RDATA) begin
                regaddr_r <= regaddr_r + 8'h01;
              end
            end
          end
          TWRS_RDATA: begin
            if (scl_fall) begin
              tx_r     <= {tx_r[6:0], 1'b1};
              bitcnt_r <= bitcnt_r + 3'd1;
              if (bitcnt_r == 3'd7) begin
                state_r <= TWRS_RACK;
              end
            end
          end
          TWRS_RACK: begin
            if (scl_rise) begin
              // Either answer is legal; not-ack ends the read
              state_r <= sda_s ? TWRS_IDLE : TWRS_ACK;
              after_ack_r <= TWRS_RDATA;
            end
          end
          default: state_r <= TWRS_IDLE;
        endcase
      end
    end
  end

  // Read data stays one byte ahead since register read data is registered
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
      busy_out   <= 1'b0;
    end else begin
      sda_out    <= 1'b0;
      sda_oe_out <= ack_drive_r || (state_r == TWRS_RDATA && !tx_r[7]);
      busy_out   <= (state_r != TWRS_IDLE);
    end
  end

  a_nack_release: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (state_r == TWRS_RACK && scl_rise && sda_s) |=> ##1 !sda_oe_out)
    else $error("line not released after not-ack");
  a_ro_no_ack: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (state_r == TWRS_WDATA && byte_end && !write_ok && !start_det && !stop_det)
    |=> (state_r == TWRS_IDLE && !ack_drive_r))
    else $error("read-only write was acknowledged");
  a_strap_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    strap_done_r |=> (strap_r == $past(strap_r)))
    else $error("slave address changed after latch");
  a_write_incr: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    wr_r |=> (regaddr_r == $past(regaddr_r) + 8'h01))
    else $error("write address did not step");
  a_addr_ack: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (state_r == TWRS_ACK && ack_pend_r && scl_fall && !start_det && !stop_det)
    |=> ##1 sda_oe_out)
    else $error("accepted byte not acknowledged");
  a_ack_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (ack_drive_r && !scl_fall && !start_det && !stop_det) |=> ack_drive_r)
    else $error("ack dropped before the clock fell");
  a_read_msb: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (state_r == TWRS_ACK && !ack_pend_r && scl_fall && after_ack_r == TWRS_RDATA &&
     !start_det && !stop_det) |=> ##1 (sda_oe_out == !tx_r[7]))
    else $error("read byte did not start with its top bit");
endmodule
`default_nettype wire

// file: dv/twrs_host_model.sv
// Host-side two-wire bus master model
`timescale 1ns/1ps
`default_nettype none
module twrs_host_model (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_drv_out
);
  // Quarter of the 320 ns bus clock; clock stands high between frames
  localparam int Q = 80;
  logic s;
  initial begin
    scl_out     = 1'b1;
    sda_drv_out = 1'b1;
  end
  // Also a repeated start when entered with the clock low; data rises a
  // quarter period late so the slave has let go of its ack first
  task automatic start();
    #Q sda_drv_out = 1'b1;
    #Q scl_out = 1'b1;
    #Q sda_drv_out = 1'b0;
    #Q scl_out = 1'b0;
  endtask
  task automatic stop();
    #Q sda_drv_out = 1'b0;
    #Q scl_out = 1'b1;
    #Q sda_drv_out = 1'b1;
    #(2 * Q);
  endtask
  // Sample mid-high: slave data settles a few clocks after the fall
  task automatic bit_io(input logic d, output logic q);
    #Q sda_drv_out = d;
    #Q scl_out = 1'b1;
    #Q q = sda_in;
    #Q scl_out = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], s); // Most significant first
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // Ack keeps the read going, not-ack marks the last byte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]); // Most significant first
    bit_io(~ack, s);
  endtask
endmodule
`default_nettype wire

// file: dv/tb_two_wire_host_register_slave.sv
// Self-checking bench of the two-wire register slave
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_host_register_slave;
  logic       clock_in   = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [2:0] strap      = 3'h0;
  logic       panel      = 1'b0;
  logic       scl, m_sda, sda_out, sda_oe, busy, ack;
  logic [7:0] cfg, b, ra;
  logic [7:0] shadow [16];
  logic       known  [16];
  logic [6:0] sa;
  int         mismatches = 0;
  int         tests_run  = 0;
  wire logic  sda_wire = m_sda & (sda_oe ? sda_out : 1'b1); // Pull-up when released
  always #20 clock_in = ~clock_in;
  twrs_host_model i_twrs_host_model (.sda_in(sda_wire), .scl_out(scl), .sda_drv_out(m_sda));
  twrs_top i_twrs_top (.clock_in(clock_in), .reset_n_in(reset_n_in), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe),
    .addr_select_bit0_in(strap[0]), .addr_select_bit1_in(strap[1]),
    .addr_select_bit2_in(strap[2]), .panel_sense_in(panel), .config_one_out(cfg),
    .busy_out(busy));
  function automatic logic wok(input logic [7:0] a);
    return a inside {8'h03, 8'h04, 8'h08, 8'h0E, 8'h0F};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hdr(input logic [6:0] a, input logic rd, input logic exp);
    i_twrs_host_model.start();
    i_twrs_host_model.wbyte({a, rd}, ack);
    check({7'h0, ack}, {7'h0, exp}); // Address acknowledged or refused as expected
  endtask
  task automatic wr(input logic [7:0] r, input int n);
    logic [7:0] d, a;
    hdr(sa, 1'b0, 1'b1);
    i_twrs_host_model.wbyte(r, ack);
    check({7'h0, ack}, 8'h01); // Register byte taken
    check({7'h0, busy}, 8'h01); // Engine busy in mid-transfer
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      a = r + 8'(i);
      i_twrs_host_model.wbyte(d, ack);
      check({7'h0, ack}, {7'h0, wok(a)}); // Increment, read-only refused
      if (ack !== 1'b1) break;
      shadow[a[3:0]] = d;
      known[a[3:0]] = 1'b1;
    end
    i_twrs_host_model.stop();
    check({7'h0, busy}, 8'h00); // Engine idle after the stop
  endtask
  task automatic rd(input logic [7:0] r, input int n);
    logic [7:0] a;
    a = r;
    hdr(sa, 1'b0, 1'b1);
    i_twrs_host_model.wbyte(r, ack);
    check({7'h0, ack}, 8'h01); // Pointer set before the read
    hdr(sa, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_twrs_host_model.rbyte(i < n - 1, b);
      if (known[a[3:0]]) check(b, shadow[a[3:0]]); // Values and increment
      a++;
    end
    #120 check({7'h0, sda_oe}, 8'h00); // Line let go after not-ack
    i_twrs_host_model.stop();
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // About 40 transfers of under 40 us each; a hang is cut well after that
  initial begin
    #2_000_000;
    mismatches++;
    give_verdict();
  end
  initial begin
    b = 8'($urandom(32'h8C15));
    for (int i = 0; i < 16; i++) known[i] = 1'b0;
    shadow[5] = twrs_pkg::RST_RESERVED;
    shadow[6] = twrs_pkg::RST_MIN_FREQ;
    shadow[8] = twrs_pkg::RST_CONFIG_ONE;
    shadow[14] = twrs_pkg::RST_ZERO;
    shadow[15] = twrs_pkg::RST_ZERO;
    for (int i = 5; i < 16; i++) known[i] = (i != 7 && i < 9) || i > 13;
    repeat (4) @(negedge clock_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clock_in);
    check(cfg, twrs_pkg::RST_CONFIG_ONE); // Reset value of the first configuration
    strap = 3'($urandom);
    sa = {twrs_pkg::ADDR_UPPER, strap};
    rd(8'h05, 4); // First access latches the straps
    $display("Test reset values done");
    @(negedge clock_in) strap = ~strap;
    hdr({twrs_pkg::ADDR_UPPER, strap}, 1'b0, 1'b0); // Later strap change ignored
    i_twrs_host_model.stop();
    hdr({4'h3, sa[2:0]}, 1'b0, 1'b0); // Wrong fixed bits
    i_twrs_host_model.stop();
    $display("Test addressing done");
    wr(8'h06, 1); // Fixed frequency byte ignores writes
    wr(8'h08, 2);
    check(cfg, shadow[8]); // Written configuration reaches the pins
    rd(8'h05, 5);
    $display("Test refused writes done");
    for (int k = 0; k < 8; k++) begin
      @(negedge clock_in) panel = 1'($urandom);
      ra = 8'h03 + 8'($urandom_range(0, 1));
      if (k % 2 == 1) ra = 8'h0E;
      if (k % 4 == 2) ra = 8'h08;
      wr(ra, 2);
      rd(ra, 2);
      check(cfg, shadow[8]); // Configuration output follows the register
      rd(8'h08, 1);
      hdr(sa, 1'b1, 1'b1);
      i_twrs_host_model.rbyte(1'b0, b);
      check({7'h0, b[twrs_pkg::PRESENCE_BIT]}, {7'h0, panel}); // Held pointer
      i_twrs_host_model.stop();
    end
    $display("Test random traffic done");
    give_verdict();
  end
endmodule
`default_nettype wire
